//--- rtl/pti_pkg.sv
// Purpose: shared constants and types of the periodic timer interrupt block
// Assumes: 10 MHz clock, AXI4-Lite register access with 32-bit data
// Notes: every offset, field position, reset value and count lives here
`default_nettype none
package pti_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_VEC_FIRST = 8'h00; // first_input_irq_vector
	localparam logic [7:0] OFF_VEC_TMR = 8'h10; // timer_irq_vector
	localparam logic [7:0] OFF_CTRL = 8'h14;
	localparam logic [7:0] OFF_STAT = 8'h18;
	localparam logic [7:0] OFF_ISTAT = 8'h1C;
	localparam logic [7:0] OFF_IMASK = 8'h20;
	// sources: 0..3 inputs two..five, 4 timer
	localparam int NSRC = 5;
	localparam logic [2:0] SRC_TMR = 3'h4;
	localparam int VEC_W = 16;
	localparam int PER_W = 8;
	// control register fields
	localparam int CTRL_PER_LSB = 0;
	localparam int CTRL_TEN_BIT = 8;
	localparam logic [31:0] CTRL_RST = 32'h0000000A;
	// status register fields (bits 4:0 are the enable flags)
	localparam int STAT_ERR_BIT = 8;
	localparam int STAT_BUSY_BIT = 9;
	localparam int STAT_DEPTH_LSB = 12;
	// interrupt event bits
	localparam int EV_TICK = 0;
	localparam int EV_DISP = 1;
	localparam int EV_ERR = 2;
	localparam int EV_W = 3;
	// period limits in milliseconds
	localparam logic [PER_W-1:0] PER_MIN_MS = 8'h0A; // 10 ms
	localparam logic [PER_W-1:0] PER_MAX_MS = 8'h8C; // 140 ms
	// timing: one millisecond in ns, clock period in ns
	localparam int MS_UNIT_NS = 1000000;
	localparam int CLK_PERIOD_NS = 100;
	localparam int CYC_PER_MS_DEF = MS_UNIT_NS / CLK_PERIOD_NS;
	// nesting limit of subroutine calls inside a routine
	localparam logic [1:0] MAX_NEST = 2'h3;
	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// dispatcher states
	typedef enum logic [1:0]
	{
		PTI_ST_IDLE = 2'h1,
		PTI_ST_SERV = 2'h2
	} pti_state_t;
endpackage : pti_pkg
`default_nettype wire

//--- rtl/pti_tick_gen.sv
// Purpose: periodic tick every configured number of milliseconds
// Assumes: period already clamped to the legal range by the caller
// Notes: counting restarts from zero whenever the enable drops
`default_nettype none
module pti_tick_gen
	import pti_pkg::*;
#(
	parameter int CYC_PER_MS = CYC_PER_MS_DEF
)
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rstn,
	// control
	input wire logic i_enable,
	input wire logic [PER_W-1:0] i_period_ms,
	// tick
	output logic o_tick
);
	logic [23:0] pre_reg;
	logic [PER_W-1:0] ms_reg;
	wire ms_done = (pre_reg == 24'(CYC_PER_MS - 1));
	// a shortened period ends the count at the next millisecond instead of wrapping
	wire per_done = ms_done && (ms_reg >= i_period_ms - 8'h01);

	// prescaler to milliseconds, then millisecond count
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn || !i_enable)
		begin
			pre_reg <= 24'h000000;
			ms_reg <= 8'h00;
			o_tick <= 1'b0;
		end
		else
		begin
			pre_reg <= ms_done ? 24'h000000 : pre_reg + 24'h000001;
			if (ms_done)
				ms_reg <= per_done ? 8'h00 : ms_reg + 8'h01;
			o_tick <= per_done;
		end
	end
endmodule : pti_tick_gen
`default_nettype wire

//--- rtl/pti_top.sv
// Purpose: periodic timer interrupt with shared serial interrupt dispatch
// Assumes: CPU core gives instruction strobes and the current address
// Notes: registers on AXI4-Lite; input edge logic sits outside
// Notes on behaviour
// - the timer requests an interrupt every period of 10 to 140 ms.
// - while running and enabled each period jumps to the timer vector.
// - the routine's return resumes at the address where it was taken.
// - all five sources become enabled whenever run state is entered.
// - mask and unmask instructions act on one named source only.
// - the timer status flag follows the timer source's enable flag, not the control enable bit.
// - a fourth nested call inside a routine raises the error flag.
// - requests during a routine wait; routines never overlap.
// - five vector registers serve inputs two to five, then the timer.
// - simultaneous requests go input two first, then three, four, five.
`default_nettype none
module pti_top
	import pti_pkg::*;
#(
	parameter int CYC_PER_MS = CYC_PER_MS_DEF
)
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rstn,
	// cpu state and instruction strobes
	input wire logic i_run,
	input wire logic [3:0] i_input_irq_req,
	input wire logic i_irq_mask_instr,
	input wire logic i_irq_unmask_instr,
	input wire logic [2:0] i_instr_src,
	input wire logic i_sub_call,
	input wire logic i_sub_return,
	input wire logic i_label_return_instr,
	input wire logic [15:0] i_pc,
	// dispatch to the cpu core
	output logic o_jump,
	output logic [VEC_W-1:0] o_jump_label,
	output logic [2:0] o_jump_src,
	output logic o_resume,
	output logic [15:0] o_resume_addr,
	output logic o_in_routine,
	output logic o_timer_irq_status_flag,
	output logic o_program_exec_error_flag,
	output logic o_err_led,
	output logic o_irq,
	// axi4-lite write channels
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read channels
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// one-hot select of a source index
	function automatic logic [NSRC-1:0] src_onehot(input logic [2:0] idx);
		src_onehot = (idx < 3'(NSRC)) ? 5'(5'h01 << idx) : 5'h00;
	endfunction : src_onehot

	// byte-lane merge of a write
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] dat, input logic [3:0] strb);
		merge = old;
		for (int k = 0; k < 4; k++)
			if (strb[k])
				merge[8*k +: 8] = dat[8*k +: 8];
	endfunction : merge
	// register storage
	logic [VEC_W-1:0] vec_reg [NSRC];
	logic [31:0] ctrl_reg;
	logic [EV_W-1:0] istat_reg;
	logic [EV_W-1:0] imask_reg;
	logic [NSRC-1:0] en_reg;
	logic [NSRC-1:0] pend_reg;
	logic run_reg;
	logic err_reg;
	logic [1:0] depth_reg;
	logic [15:0] ret_reg;
	pti_state_t state_reg;
	// bus bookkeeping
	logic aw_have_reg, w_have_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	// timer period clamped to the legal range
	wire [PER_W-1:0] per_raw = ctrl_reg[CTRL_PER_LSB +: PER_W];
	wire [PER_W-1:0] per_ms = (per_raw < PER_MIN_MS) ? PER_MIN_MS :
		(per_raw > PER_MAX_MS) ? PER_MAX_MS : per_raw;
	wire timer_on = i_run && ctrl_reg[CTRL_TEN_BIT] && en_reg[SRC_TMR];
	wire tick;
	pti_tick_gen #(.CYC_PER_MS(CYC_PER_MS)) u_tick
	(
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.i_enable(timer_on),
		.i_period_ms(per_ms),
		.o_tick(tick)
	);
	// instruction decode and request vector
	wire [NSRC-1:0] mask_sel =
		i_irq_mask_instr ? src_onehot(i_instr_src) : 5'h00;
	wire [NSRC-1:0] unmask_sel =
		i_irq_unmask_instr ? src_onehot(i_instr_src) : 5'h00;
	wire [NSRC-1:0] req = {tick, i_input_irq_req};
	wire run_enter = i_run && !run_reg;
	wire idle = (state_reg == PTI_ST_IDLE);
	// lowest index wins: inputs two..five, then timer
	wire [NSRC-1:0] grant = pend_reg & (~pend_reg + 5'h01);
	wire take = idle && i_run && (pend_reg != 5'h00);
	logic [2:0] grant_idx;
	always_comb
	begin
		grant_idx = 3'h0;
		for (int j = NSRC - 1; j >= 0; j--)
			if (grant[j])
				grant_idx = 3'(j);
	end
	// routine end and nesting overflow
	wire finish = !idle && i_label_return_instr;
	wire nest_err = !idle && i_sub_call && (depth_reg == MAX_NEST);
	// enable flags and pending requests per source
	genvar g;
	generate
		for (g = 0; g < NSRC; g++)
		begin : g_src
			always_ff @(posedge i_mclk)
			begin
				if (!i_rstn)
				begin
					en_reg[g] <= 1'b0;
					pend_reg[g] <= 1'b0;
				end
				else
				begin
					if (run_enter || unmask_sel[g])
						en_reg[g] <= 1'b1;
					else if (mask_sel[g] || !i_run)
						en_reg[g] <= 1'b0;
					// disabled sources keep nothing pending
					if (!i_run || !en_reg[g] || mask_sel[g])
						pend_reg[g] <= 1'b0;
					else if (req[g])
						pend_reg[g] <= 1'b1;
					else if (take && grant[g])
						pend_reg[g] <= 1'b0;
				end
			end
		end
	endgenerate
	// dispatcher: one routine at a time
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			state_reg <= PTI_ST_IDLE;
			run_reg <= 1'b0;
			ret_reg <= 16'h0000;
			depth_reg <= 2'h0;
			o_jump <= 1'b0;
			o_jump_label <= 16'h0000;
			o_jump_src <= 3'h0;
			o_resume <= 1'b0;
			o_resume_addr <= 16'h0000;
		end
		else
		begin
			run_reg <= i_run;
			o_jump <= take;
			o_resume <= finish;
			case (state_reg)
				PTI_ST_IDLE:
				begin
					depth_reg <= 2'h0;
					if (take)
					begin
						state_reg <= PTI_ST_SERV;
						ret_reg <= i_pc;
						o_jump_label <= vec_reg[grant_idx];
						o_jump_src <= grant_idx;
					end
				end
				PTI_ST_SERV:
				begin
					if (i_sub_call && depth_reg != MAX_NEST)
						depth_reg <= depth_reg + 2'h1;
					else if (i_sub_return && depth_reg != 2'h0)
						depth_reg <= depth_reg - 2'h1;
					if (finish || !i_run)
					begin
						state_reg <= PTI_ST_IDLE;
						o_resume_addr <= ret_reg;
					end
				end
				default:
					state_reg <= PTI_ST_IDLE;
			endcase
		end
	end

	// axi4-lite handshakes and decode
	assign s_axi_awready = !aw_have_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_have_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	wire do_wr = aw_have_reg && w_have_reg && !s_axi_bvalid;
	wire do_rd = s_axi_arvalid && s_axi_arready;
	wire wr_vec = do_wr && (awaddr_reg <= OFF_VEC_TMR) &&
		(awaddr_reg[1:0] == 2'h0);
	wire [2:0] wr_vidx = awaddr_reg[4:2];
	wire [31:0] vec_wr_word = merge({16'h0000, vec_reg[wr_vidx]},
		wdata_reg, wstrb_reg);
	wire wr_ok = wr_vec || (awaddr_reg == OFF_CTRL) ||
		(awaddr_reg == OFF_STAT) || (awaddr_reg == OFF_IMASK) ||
		(awaddr_reg == OFF_ISTAT);
	wire rd_istat = do_rd && (s_axi_araddr == OFF_ISTAT);
	wire clr_err = do_wr && (awaddr_reg == OFF_STAT) &&
		wstrb_reg[1] && wdata_reg[STAT_ERR_BIT];
	wire [EV_W-1:0] ev = {nest_err, take, tick};
	// read mux, unmapped reads return zero with an error
	logic [31:0] rd_val;
	logic rd_ok;
	always_comb
	begin
		rd_val = 32'h00000000;
		rd_ok = 1'b1;
		if (s_axi_araddr <= OFF_VEC_TMR && s_axi_araddr[1:0] == 2'h0)
			rd_val = {16'h0000, vec_reg[s_axi_araddr[4:2]]};
		else
		case (s_axi_araddr)
			OFF_CTRL: rd_val = ctrl_reg;
			OFF_STAT: rd_val = {16'h0000, 2'h0, depth_reg, 2'h0,
				!idle, err_reg, 3'h0, en_reg};
			OFF_ISTAT: rd_val = {29'h0, istat_reg};
			OFF_IMASK: rd_val = {29'h0, imask_reg};
			default: rd_ok = 1'b0;
		endcase
	end

	// bus channel state
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h00000000;
			wstrb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_have_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_have_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (do_wr)
			begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (do_rd)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_val;
				s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// software registers, error flag and sticky events
	always_ff @(posedge i_mclk)
	begin
		if (!i_rstn)
		begin
			for (int v = 0; v < NSRC; v++)
				vec_reg[v] <= 16'h0000;
			ctrl_reg <= CTRL_RST;
			imask_reg <= 3'h0;
			istat_reg <= 3'h0;
			err_reg <= 1'b0;
		end
		else
		begin
			if (wr_vec)
				vec_reg[wr_vidx] <= vec_wr_word[VEC_W-1:0];
			if (do_wr && awaddr_reg == OFF_CTRL)
				ctrl_reg <= merge(ctrl_reg, wdata_reg, wstrb_reg) &
					32'h000001FF;
			if (do_wr && awaddr_reg == OFF_IMASK && wstrb_reg[0])
				imask_reg <= wdata_reg[EV_W-1:0];
			// a new event wins over the clear by read
			istat_reg <= (rd_istat ? 3'h0 : istat_reg) | ev;
			if (nest_err)
				err_reg <= 1'b1;
			else if (clr_err)
				err_reg <= 1'b0;
		end
	end
	// outputs built from state
	assign o_in_routine = !idle;
	assign o_timer_irq_status_flag = en_reg[SRC_TMR];
	assign o_program_exec_error_flag = err_reg;
	assign o_err_led = err_reg;
	assign o_irq = |(istat_reg & imask_reg);
endmodule : pti_top
`default_nettype wire

//--- test/pti_chk.sv
// Purpose: concurrent checks on the dispatch ports of the timer block
// Assumes: one clock, synchronous active-low reset
// Notes: sees only ports of pti_top and is bound to it below
`default_nettype none
module pti_chk
	import pti_pkg::*;
(
	// clock, reset and cpu strobes
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_run,
	input wire logic i_irq_mask_instr,
	input wire logic i_irq_unmask_instr,
	input wire logic [2:0] i_instr_src,
	input wire logic i_sub_call,
	input wire logic i_label_return_instr,
	// dispatch outputs
	input wire logic o_jump,
	input wire logic o_resume,
	input wire logic o_in_routine,
	input wire logic o_timer_irq_status_flag,
	input wire logic o_program_exec_error_flag,
	input wire logic o_err_led
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);
	// the instruction names the timer source
	wire tsel = i_instr_src == SRC_TMR;
	// entry followed by four nested calls, and a routine end
	sequence s_enter;
		o_jump ##1 (i_sub_call && o_in_routine) [*4];
	endsequence
	sequence s_ret;
		i_label_return_instr && o_in_routine && i_run;
	endsequence
	a_jump_single: assert property (o_jump |=> !o_jump)
		else $error("jump pulse longer than one cycle");
	a_jump_enter: assert property (o_jump |-> o_in_routine &&
		!$past(o_in_routine)) else $error("routine entered twice");
	a_jump_run: assert property (o_jump |-> $past(i_run))
		else $error("jump while not running");
	a_resume_cause: assert property (s_ret |=> o_resume &&
		!o_in_routine) else $error("routine end not resumed");
	a_resume_only: assert property (o_resume |-> $past(o_in_routine))
		else $error("resume outside a routine");
	a_flag_unmask: assert property (i_run && i_irq_unmask_instr &&
		tsel |=> o_timer_irq_status_flag) else $error("unmask lost");
	a_flag_mask: assert property (i_run && $past(i_run) && tsel &&
		i_irq_mask_instr && !i_irq_unmask_instr |=> !o_timer_irq_status_flag)
		else $error("mask lost");
	a_run_enable: assert property ($rose(i_run) |=>
		o_timer_irq_status_flag) else $error("run entry left timer off");
	a_nest_err: assert property (s_enter |=> o_program_exec_error_flag)
		else $error("fourth nested call not flagged");
	a_err_led: assert property (o_err_led == o_program_exec_error_flag)
		else $error("error lamp differs from flag");
endmodule : pti_chk
bind pti_top pti_chk pti_chk_i (.*);
`default_nettype wire

//--- test/test_periodic_timer_interrupt.sv
// Purpose: self-checking bench for the periodic timer interrupt block
// Assumes: ten clock cycles stand for one millisecond
// Notes: inputs change by non-blocking assignment at the rising edge
`default_nettype none
module test_periodic_timer_interrupt
	import pti_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int CPM = 10;
	logic i_mclk, i_rstn, i_run, i_irq_mask_instr, i_irq_unmask_instr;
	logic i_sub_call, i_sub_return, i_label_return_instr, o_jump, o_irq;
	logic [3:0] i_input_irq_req, s_axi_wstrb;
	logic [2:0] i_instr_src, o_jump_src;
	logic [15:0] i_pc, o_resume_addr, o_jump_label;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic s_axi_arready, s_axi_rvalid, o_resume, o_in_routine;
	logic o_timer_irq_status_flag, o_program_exec_error_flag, o_err_led;
	int err_total, samples_checked, t0, t1, per;
	int cyc = 0;
	// one row per source: index, vector, address at dispatch
	typedef struct {logic [2:0] s; logic [15:0] v, p;} pti_row_t;
	pti_row_t rows [5] = '{'{3'h0, 16'h0001, 16'h1000},
		'{3'h1, 16'h00FE, 16'h2222}, '{3'h2, 16'h7F00, 16'h3C3C},
		'{3'h3, 16'h8001, 16'h4321}, '{3'h4, 16'hFFFF, 16'hABCD}};
	pti_top #(.CYC_PER_MS(CPM)) pti_top_i (.*);
	// clock and cycle count
	initial
	begin
		i_mclk = 1'h0;
		forever #50 i_mclk = ~i_mclk;
	end
	always @(posedge i_mclk) cyc <= cyc + 1;
	// comparison and verdict
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic complete_run;
		if (err_total == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	// bus cycles, request pulses and routine end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do
		begin
			@(posedge i_mclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end
		while (s_axi_bvalid !== 1'h1);
		rr = s_axi_bresp;
		s_axi_bready <= 1'h0;
	endtask : wr
	task automatic rdreg(input logic [7:0] a);
		@(posedge i_mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		do
		begin
			@(posedge i_mclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'h0;
		end
		while (s_axi_rvalid !== 1'h1);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 1'h0;
	endtask : rdreg
	task automatic req(input logic [3:0] m);
		@(posedge i_mclk);
		i_input_irq_req <= m;
		@(posedge i_mclk);
		i_input_irq_req <= 4'h0;
	endtask : req
	task automatic instr(input logic mk, input logic [2:0] s);
		@(posedge i_mclk);
		i_instr_src <= s;
		i_irq_mask_instr <= mk;
		i_irq_unmask_instr <= !mk;
		@(posedge i_mclk);
		i_irq_mask_instr <= 1'h0;
		i_irq_unmask_instr <= 1'h0;
	endtask : instr
	task automatic wjump;
		do @(posedge i_mclk);
		while (o_jump !== 1'h1);
		t0 = cyc;
	endtask : wjump
	task automatic label_return_instr;
		logic [15:0] pa;
		pa = i_pc;
		@(posedge i_mclk);
		i_label_return_instr <= 1'h1;
		i_pc <= ~pa; // routine code lies past the main end
		@(posedge i_mclk);
		i_label_return_instr <= 1'h0;
		i_pc <= pa;
		@(posedge i_mclk);
		check(o_resume, 1);
		check(o_resume_addr, pa);
	endtask : label_return_instr
	// watchdog
	initial
	begin
		repeat (20000) @(posedge i_mclk);
		err_total++;
		complete_run();
	end
	// main sequence
	initial
	begin
		{err_total, samples_checked, i_rstn, i_run, i_pc} = 0;
		{i_irq_mask_instr, i_irq_unmask_instr, i_instr_src} = 0;
		{i_sub_call, i_sub_return, i_label_return_instr, i_input_irq_req} = 0;
		{s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = 0;
		{s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = 0;
		s_axi_wstrb = 4'hF;
		repeat (12) @(posedge i_mclk);
		i_rstn <= 1'h1;
		@(posedge i_mclk);
		check(o_timer_irq_status_flag, 0);
		rdreg(OFF_CTRL);
		check(rd, CTRL_RST);
		rdreg(8'h40);
		check(rr, RESP_SLVERR);
		wr(8'h40, 32'h0000FFFF);
		check(rr, RESP_SLVERR);
		i_run <= 1'h1;
		repeat (2) @(posedge i_mclk);
		check(o_timer_irq_status_flag, 1);
		foreach (rows[k])
		begin
			wr(OFF_VEC_FIRST + 8'(4 * rows[k].s), 32'(rows[k].v));
			check(rr, RESP_OKAY);
			i_pc <= rows[k].p;
			if (rows[k].s == SRC_TMR)
				wr(OFF_CTRL, 32'h0000010A);
			else
				req(4'h1 << rows[k].s);
			wjump();
			check(o_jump_src, rows[k].s);
			check(o_jump_label, rows[k].v);
			label_return_instr();
		end
		wr(OFF_CTRL, CTRL_RST);
		req(4'hF);
		for (int k = 0; k < 4; k++)
		begin
			wjump();
			check(o_jump_src, k);
			label_return_instr();
		end
		instr(1'h1, 3'h1); // outside any routine
		req(4'h6);
		wjump();
		check(o_jump_src, 2);
		label_return_instr();
		repeat (5) @(posedge i_mclk);
		check(o_in_routine, 0);
		instr(1'h0, 3'h1);
		instr(1'h1, SRC_TMR);
		@(posedge i_mclk);
		check(o_timer_irq_status_flag, 0);
		wr(OFF_CTRL, 32'h0000010A);
		repeat (150) @(posedge i_mclk);
		instr(1'h0, SRC_TMR);
		@(posedge i_mclk);
		check(o_timer_irq_status_flag, 1);
		repeat (20) @(posedge i_mclk);
		check(o_in_routine, 0);
		wjump();
		label_return_instr();
		for (int k = 0; k < 2; k++)
		begin
			per = k ? PER_MAX_MS : PER_MIN_MS;
			wr(OFF_CTRL, CTRL_RST);
			wr(OFF_CTRL, 32'h100 | per);
			wjump();
			t1 = t0;
			label_return_instr(); // returns long before the next period
			wjump();
			check(t0 - t1, per * CPM);
			label_return_instr();
		end
		wr(OFF_CTRL, CTRL_RST);
		req(4'h1);
		wjump();
		i_sub_call <= 1'h1;
		repeat (4) @(posedge i_mclk);
		check(o_program_exec_error_flag, 0);
		i_sub_call <= 1'h0;
		@(posedge i_mclk);
		check({o_program_exec_error_flag, o_err_led, o_irq}, 6);
		wr(OFF_IMASK, 32'h4);
		@(posedge i_mclk);
		check(o_irq, 1);
		rdreg(OFF_ISTAT);
		check(rd[EV_ERR], 1);
		@(posedge i_mclk);
		check(o_irq, 0);
		wr(OFF_STAT, 32'h100);
		@(posedge i_mclk);
		check(o_program_exec_error_flag, 0);
		// one return makes room for exactly one more call
		i_sub_return <= 1'h1;
		@(posedge i_mclk);
		i_sub_return <= 1'h0;
		i_sub_call <= 1'h1;
		@(posedge i_mclk);
		i_sub_call <= 1'h0;
		@(posedge i_mclk);
		check(o_program_exec_error_flag, 0);
		i_sub_call <= 1'h1;
		@(posedge i_mclk);
		i_sub_call <= 1'h0;
		@(posedge i_mclk);
		check(o_program_exec_error_flag, 1);
		label_return_instr();
		i_rstn <= 1'h0;
		repeat (2) @(posedge i_mclk);
		i_rstn <= 1'h1;
		repeat (3) @(posedge i_mclk);
		check(o_timer_irq_status_flag, 1);
		complete_run();
	end
endmodule : test_periodic_timer_interrupt
`default_nettype wire
